// ### include/data_memory_pkg.sv
// shared constants and types for the banked data memory decoder
package data_memory_pkg;

   // unbanked core addresses
   localparam logic [7:0] ADDR_INDIRECT_PORT_ZERO = 8'h00;
   localparam logic [7:0] ADDR_POINTER_ZERO       = 8'h01;
   localparam logic [7:0] ADDR_CORE_LOW_FIRST     = 8'h02;
   localparam logic [7:0] ADDR_CORE_LOW_LAST      = 8'h07;
   localparam logic [7:0] ADDR_INDIRECT_PORT_ONE  = 8'h08;
   localparam logic [7:0] ADDR_POINTER_ONE        = 8'h09;
   localparam logic [7:0] ADDR_CORE_HIGH_FIRST    = 8'h0a;
   localparam logic [7:0] ADDR_CORE_HIGH_LAST     = 8'h0e;
   localparam logic [7:0] ADDR_BANK_SELECTOR      = 8'h0f;
   localparam logic [7:0] ADDR_CORE_PRODUCT_FIRST = 8'h18;
   localparam logic [7:0] ADDR_CORE_PRODUCT_LAST  = 8'h19;

   // banked special registers
   localparam logic [7:0] ADDR_PERIPH_FIRST = 8'h10;
   localparam logic [7:0] ADDR_PERIPH_LAST  = 8'h17;
   localparam int         PERIPH_BANKS_MAX  = 9;

   // general ram: six shared bytes and the banked pages
   localparam logic [7:0] ADDR_SHARED_FIRST = 8'h1a;
   localparam logic [7:0] ADDR_SHARED_LAST  = 8'h1f;
   localparam logic [7:0] ADDR_RAM_FIRST    = 8'h20;
   localparam int         SHARED_COUNT      = 6;
   localparam int         RAM_BANK_SIZE     = 224;
   localparam int         RAM_BANKS_MAX     = 4;
   localparam int         RAM_DEPTH         = RAM_BANKS_MAX * RAM_BANK_SIZE + SHARED_COUNT;
   localparam int         RAM_INDEX_WIDTH   = 10;

   // peripheral-side operand range of the move instructions
   localparam int         PERIPH_OPERAND_WIDTH = 5;

   // bank selector fields
   localparam int         SEL_PERIPH_LSB = 0;
   localparam int         SEL_RAM_LSB    = 4;
   localparam int         SEL_FIELD_W    = 4;

   // reset values
   localparam logic [7:0] RESET_BANK_SELECTOR = 8'h00;
   localparam logic [7:0] RESET_POINTER       = 8'h00;
   localparam logic [7:0] UNIMPLEMENTED_VALUE = 8'h00;

   typedef enum logic [2:0] {
      op_read,
      op_write,
      op_move_periph_to_file,
      op_move_file_to_periph,
      op_load_ram_bank_literal,
      op_load_periph_bank_literal
   } op_kind_t;

   typedef enum logic [2:0] {
      tgt_none,
      tgt_pointer_zero,
      tgt_pointer_one,
      tgt_bank_selector,
      tgt_core,
      tgt_periph,
      tgt_ram
   } target_kind_t;

   typedef struct packed {
      target_kind_t                 kind;
      logic [RAM_INDEX_WIDTH-1:0]   ram_index;
      logic [SEL_FIELD_W-1:0]       bank;
      logic [7:0]                   offset;
   } target_t;

   typedef enum logic [1:0] {
      st_idle,
      st_fetch,
      st_store
   } seq_state_t;

endpackage

// ### include/ram_port_if.sv
// port between the decoder and the general ram array
`timescale 1ns/1ps
interface ram_port_if;
   logic [data_memory_pkg::RAM_INDEX_WIDTH-1:0] addr;
   logic                                        write_en;
   logic [7:0]                                  write_data;
   logic [7:0]                                  read_data;

   modport owner (output addr, output write_en, output write_data, input read_data);
   modport store (input addr, input write_en, input write_data, output read_data);
endinterface // ram_port_if

// ### verilog/general_ram_store.sv
// byte-wide general ram array, never reset
`timescale 1ns/1ps
module general_ram_store #(
   parameter int DEPTH = data_memory_pkg::RAM_DEPTH
) (
   input  wire logic clock,
   ram_port_if.store port
);

   logic [7:0] mem [DEPTH];

   // no reset term: contents survive every reset
   always_ff @(posedge clock) begin
      if (port.write_en) begin
         mem[port.addr] <= port.write_data;
      end
   end

   // asynchronous read keeps a fetch inside one cycle
   assign port.read_data = mem[port.addr];

endmodule // general_ram_store

// ### verilog/banked_data_memory_decoder.sv
// banked data memory decoder
//
// Overview of operation
// - bank general ram beyond 230 bytes
// - unbanked addresses ignore the bank selector
// - moves: operand 0h-1Fh against 0h-FFh
// - six spare operand locations are ram
// - direct and pointer access reach everything
// - each ram location holds one byte
// - ram untouched by every reset
// - literal load of the ram bank
// - literal load of the peripheral bank
// - peripherals banked, core registers unbanked
// - 10h-17h banked by selector low nibble
// - ram pages banked by selector high nibble
// - unimplemented addresses read zero
// - ram bank 3 absent on small variants
// - peripheral bank 8 only on large variants
// - data memory always on chip
`timescale 1ns/1ps
module banked_data_memory_decoder #(
   parameter int RAM_BANKS        = 4,
   parameter bit HAS_PERIPH_BANK8 = 1'b1
) (
   input  wire logic       clock,
   input  wire logic       reset_n,
   input  wire logic       op_valid,
   input  wire data_memory_pkg::op_kind_t op_kind,
   input  wire logic [7:0] op_file_addr,
   input  wire logic [data_memory_pkg::PERIPH_OPERAND_WIDTH-1:0] op_periph_addr,
   input  wire logic [7:0] op_data,
   output logic            busy,
   output logic            op_done,
   output logic [7:0]      read_data,
   output logic            core_read,
   output logic            core_write,
   output logic            periph_read,
   output logic            periph_write,
   output logic [3:0]      ext_bank,
   output logic [7:0]      ext_offset,
   output logic [7:0]      ext_write_data,
   input  wire logic [7:0] core_read_data,
   input  wire logic [7:0] periph_read_data,
   output logic [7:0]      pointer_zero,
   output logic [7:0]      pointer_one,
   output logic [7:0]      bank_selector
);

   // reset release
   logic rst_meta;
   logic rst_n;

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // sequencer state
   data_memory_pkg::seq_state_t state;
   data_memory_pkg::seq_state_t next_state;
   data_memory_pkg::op_kind_t   kind_q;
   data_memory_pkg::target_t    cur_tgt;
   data_memory_pkg::target_t    next_tgt;
   logic [7:0]                  dst_addr;
   logic [7:0]                  next_addr;
   logic [7:0]                  fetched;
   logic                        accept;
   logic                        is_literal;

   ram_port_if ram ();

   general_ram_store #(
      .DEPTH (data_memory_pkg::RAM_DEPTH)
   ) u_store (
      .clock (clock),
      .port  (ram.store)
   );

   function automatic logic in_range(input logic [7:0] a, input logic [7:0] lo,
      input logic [7:0] hi);
      in_range = (a >= lo) && (a <= hi);
   endfunction

   // turn an 8-bit file address into a storage target
   function automatic data_memory_pkg::target_t resolve(input logic [7:0] addr,
      input logic [7:0] sel,
      input logic [7:0] p0,
      input logic [7:0] p1);
      data_memory_pkg::target_t    t;
      logic [7:0]                  eff;
      logic [3:0]                  pbank;
      logic [3:0]                  rbank;
      logic [7:0]                  rel;
      t        = '0;
      eff      = addr;
      pbank    = sel[data_memory_pkg::SEL_PERIPH_LSB +: data_memory_pkg::SEL_FIELD_W];
      rbank    = sel[data_memory_pkg::SEL_RAM_LSB +: data_memory_pkg::SEL_FIELD_W];
      rel      = 8'h00;
      // indirect port swaps in its pointer
      // pointer access reuses the normal decode
      if (addr == data_memory_pkg::ADDR_INDIRECT_PORT_ZERO) begin
         eff = p0;
      end else if (addr == data_memory_pkg::ADDR_INDIRECT_PORT_ONE) begin
         eff = p1;
      end
      t.offset = eff;
      t.bank   = pbank;
      // pointer aimed at an indirect port is absent
      if (eff == data_memory_pkg::ADDR_INDIRECT_PORT_ZERO ||
          eff == data_memory_pkg::ADDR_INDIRECT_PORT_ONE) begin
         t.kind = data_memory_pkg::tgt_none;
      end else if (eff == data_memory_pkg::ADDR_POINTER_ZERO) begin
         t.kind = data_memory_pkg::tgt_pointer_zero;
      end else if (eff == data_memory_pkg::ADDR_POINTER_ONE) begin
         t.kind = data_memory_pkg::tgt_pointer_one;
      end else if (eff == data_memory_pkg::ADDR_BANK_SELECTOR) begin
         t.kind = data_memory_pkg::tgt_bank_selector;
      end else if (in_range(eff, data_memory_pkg::ADDR_CORE_LOW_FIRST,
                            data_memory_pkg::ADDR_CORE_LOW_LAST) ||
                   in_range(eff, data_memory_pkg::ADDR_CORE_HIGH_FIRST,
                            data_memory_pkg::ADDR_CORE_HIGH_LAST) ||
                   in_range(eff, data_memory_pkg::ADDR_CORE_PRODUCT_FIRST,
                            data_memory_pkg::ADDR_CORE_PRODUCT_LAST)) begin
         t.kind = data_memory_pkg::tgt_core;
         t.bank = 4'h0;
      end else if (in_range(eff, data_memory_pkg::ADDR_PERIPH_FIRST,
                            data_memory_pkg::ADDR_PERIPH_LAST)) begin
         if (32'(pbank) < data_memory_pkg::PERIPH_BANKS_MAX - 1 ||
             (32'(pbank) == data_memory_pkg::PERIPH_BANKS_MAX - 1 && HAS_PERIPH_BANK8)) begin
            t.kind = data_memory_pkg::tgt_periph;
         end
      // spare operand locations are plain ram
      end else if (in_range(eff, data_memory_pkg::ADDR_SHARED_FIRST,
                            data_memory_pkg::ADDR_SHARED_LAST)) begin
         rel         = eff - data_memory_pkg::ADDR_SHARED_FIRST;
         t.kind      = data_memory_pkg::tgt_ram;
         t.ram_index = data_memory_pkg::RAM_INDEX_WIDTH'(
                          data_memory_pkg::RAM_BANKS_MAX * data_memory_pkg::RAM_BANK_SIZE)
                       + data_memory_pkg::RAM_INDEX_WIDTH'(rel);
      end else begin
         // pages extend ram past one window
         // missing banks fall through as absent
         rel = eff - data_memory_pkg::ADDR_RAM_FIRST;
         if (32'(rbank) < RAM_BANKS) begin
            t.kind      = data_memory_pkg::tgt_ram;
            t.ram_index = data_memory_pkg::RAM_INDEX_WIDTH'(rbank)
                          * data_memory_pkg::RAM_INDEX_WIDTH'(data_memory_pkg::RAM_BANK_SIZE)
                          + data_memory_pkg::RAM_INDEX_WIDTH'(rel);
         end
      end
      resolve = t;
   endfunction

   assign accept     = (state == data_memory_pkg::st_idle) && op_valid;
   assign is_literal = (op_kind == data_memory_pkg::op_load_ram_bank_literal) ||
                       (op_kind == data_memory_pkg::op_load_periph_bank_literal);

   // next state and the address that the next cycle works on
   always_comb begin
      next_state = state;
      next_addr  = dst_addr;
      unique case (state)
         data_memory_pkg::st_idle: begin
            if (accept) begin
               unique case (op_kind)
                  data_memory_pkg::op_read: begin
                     next_state = data_memory_pkg::st_fetch;
                     next_addr  = op_file_addr;
                  end
                  data_memory_pkg::op_write: begin
                     next_state = data_memory_pkg::st_store;
                     next_addr  = op_file_addr;
                  end
                  // peripheral operand limited to 5 bits
                  data_memory_pkg::op_move_periph_to_file: begin
                     next_state = data_memory_pkg::st_fetch;
                     next_addr  = {3'b000, op_periph_addr};
                  end
                  data_memory_pkg::op_move_file_to_periph: begin
                     next_state = data_memory_pkg::st_fetch;
                     next_addr  = op_file_addr;
                  end
                  default: begin
                     next_state = data_memory_pkg::st_idle;
                  end
               endcase
            end
         end
         data_memory_pkg::st_fetch: begin
            if (kind_q == data_memory_pkg::op_read) begin
               next_state = data_memory_pkg::st_idle;
            end else begin
               next_state = data_memory_pkg::st_store;
            end
         end
         data_memory_pkg::st_store: begin
            next_state = data_memory_pkg::st_idle;
         end
      endcase
      next_tgt = resolve(next_addr, bank_selector, pointer_zero, pointer_one);
   end

   // value seen at the current target
   always_comb begin
      unique case (cur_tgt.kind)
         data_memory_pkg::tgt_pointer_zero:  fetched = pointer_zero;
         data_memory_pkg::tgt_pointer_one:   fetched = pointer_one;
         data_memory_pkg::tgt_bank_selector: fetched = bank_selector;
         data_memory_pkg::tgt_core:          fetched = core_read_data;
         data_memory_pkg::tgt_periph:        fetched = periph_read_data;
         data_memory_pkg::tgt_ram:           fetched = ram.read_data;
         default:                            fetched = data_memory_pkg::UNIMPLEMENTED_VALUE;
      endcase
   end

   assign ram.addr       = cur_tgt.ram_index;
   assign ram.write_data = ext_write_data;
   // writes to absent locations are simply dropped
   assign ram.write_en   = (state == data_memory_pkg::st_store) &&
                           (cur_tgt.kind == data_memory_pkg::tgt_ram);

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state <= data_memory_pkg::st_idle;
         busy  <= 1'b0;
      end else begin
         state <= next_state;
         busy  <= (next_state != data_memory_pkg::st_idle);
      end
   end

   // operation latches
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         kind_q   <= data_memory_pkg::op_read;
         dst_addr <= 8'h00;
         cur_tgt  <= '0;
      end else begin
         cur_tgt <= next_tgt;
         if (accept) begin
            kind_q <= op_kind;
            if (op_kind == data_memory_pkg::op_move_file_to_periph) begin
               dst_addr <= {3'b000, op_periph_addr};
            end else begin
               dst_addr <= op_file_addr;
            end
         end
      end
   end

   // answers to the core
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         op_done   <= 1'b0;
         read_data <= 8'h00;
      end else begin
         op_done <= (accept && is_literal) ||
                    (state == data_memory_pkg::st_store) ||
                    (state == data_memory_pkg::st_fetch &&
                     kind_q == data_memory_pkg::op_read);
         if (state == data_memory_pkg::st_fetch &&
             kind_q == data_memory_pkg::op_read) begin
            read_data <= fetched;
         end
      end
   end

   // strobes set one cycle ahead; write data doubles as store data
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         core_read      <= 1'b0;
         core_write     <= 1'b0;
         periph_read    <= 1'b0;
         periph_write   <= 1'b0;
         ext_bank       <= 4'h0;
         ext_offset     <= 8'h00;
         ext_write_data <= 8'h00;
      end else begin
         core_read      <= (next_state == data_memory_pkg::st_fetch) &&
                           (next_tgt.kind == data_memory_pkg::tgt_core);
         core_write     <= (next_state == data_memory_pkg::st_store) &&
                           (next_tgt.kind == data_memory_pkg::tgt_core);
         periph_read    <= (next_state == data_memory_pkg::st_fetch) &&
                           (next_tgt.kind == data_memory_pkg::tgt_periph);
         periph_write   <= (next_state == data_memory_pkg::st_store) &&
                           (next_tgt.kind == data_memory_pkg::tgt_periph);
         ext_bank       <= next_tgt.bank;
         ext_offset     <= next_tgt.offset;
         if (accept) begin
            ext_write_data <= op_data;
         end else if (state == data_memory_pkg::st_fetch) begin
            ext_write_data <= fetched;
         end
      end
   end

   // pointers
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pointer_zero <= data_memory_pkg::RESET_POINTER;
         pointer_one  <= data_memory_pkg::RESET_POINTER;
      end else if (state == data_memory_pkg::st_store) begin
         if (cur_tgt.kind == data_memory_pkg::tgt_pointer_zero) begin
            pointer_zero <= ext_write_data;
         end
         if (cur_tgt.kind == data_memory_pkg::tgt_pointer_one) begin
            pointer_one <= ext_write_data;
         end
      end
   end

   // bank selector: stores and the two literal loads
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         bank_selector <= data_memory_pkg::RESET_BANK_SELECTOR;
      end else if (accept && op_kind == data_memory_pkg::op_load_ram_bank_literal) begin
         bank_selector[data_memory_pkg::SEL_RAM_LSB +: data_memory_pkg::SEL_FIELD_W]
            <= op_data[data_memory_pkg::SEL_FIELD_W-1:0];
      end else if (accept && op_kind == data_memory_pkg::op_load_periph_bank_literal) begin
         bank_selector[data_memory_pkg::SEL_PERIPH_LSB +: data_memory_pkg::SEL_FIELD_W]
            <= op_data[data_memory_pkg::SEL_FIELD_W-1:0];
      end else if (state == data_memory_pkg::st_store &&
                   cur_tgt.kind == data_memory_pkg::tgt_bank_selector) begin
         bank_selector <= ext_write_data;
      end
   end

endmodule // banked_data_memory_decoder

// ### verification/ext_register_model.sv
// core and peripheral registers that sit outside the decoder
`timescale 1ns/1ps
module ext_register_model (
   input  wire logic       clock,
   input  wire logic       core_read,
   input  wire logic       core_write,
   input  wire logic       periph_read,
   input  wire logic       periph_write,
   input  wire logic [3:0] ext_bank,
   input  wire logic [7:0] ext_offset,
   input  wire logic [7:0] ext_write_data,
   output logic      [7:0] core_read_data,
   output logic      [7:0] periph_read_data
);
   logic [7:0] core [0:31];
   logic [7:0] periph [0:8][0:7];
   logic [7:0] last_core;
   logic [7:0] last_periph;

   initial begin
      last_core = 8'h00;
      last_periph = 8'h00;
      for (int i = 0; i < 32; i++) core[i] = 8'(8'hc0 + i);
      for (int b = 0; b < 9; b++) begin
         for (int o = 0; o < 8; o++) periph[b][o] = 8'(8'h80 + b * 8 + o);
      end
   end

   // unselected: inverse of last value
   always_comb begin
      core_read_data = core_read ? core[ext_offset[4:0]] : ~last_core;
      periph_read_data = periph_read ? periph[ext_bank][ext_offset[2:0]] : ~last_periph;
   end

   always @(posedge clock) begin
      if (core_read) last_core <= core_read_data;
      if (periph_read) last_periph <= periph_read_data;
      if (core_write) core[ext_offset[4:0]] <= ext_write_data;
      if (periph_write) periph[ext_bank][ext_offset[2:0]] <= ext_write_data;
   end
endmodule // ext_register_model

// ### verification/data_memory_sva.sv
// port assertions for the banked data memory decoder
`timescale 1ns/1ps
module data_memory_sva #(
   parameter int RAM_BANKS        = 4,
   parameter bit HAS_PERIPH_BANK8 = 1'b1
) (
   input wire logic                      clock,
   input wire logic                      reset_n,
   input wire logic                      op_valid,
   input wire data_memory_pkg::op_kind_t op_kind,
   input wire logic [7:0]                op_file_addr,
   input wire logic [4:0]                op_periph_addr,
   input wire logic [7:0]                op_data,
   input wire logic                      busy,
   input wire logic                      op_done,
   input wire logic [7:0]                read_data,
   input wire logic                      core_read,
   input wire logic                      core_write,
   input wire logic                      periph_read,
   input wire logic                      periph_write,
   input wire logic [3:0]                ext_bank,
   input wire logic [7:0]                ext_offset,
   input wire logic [7:0]                bank_selector
);
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);
   logic tk;
   logic per;
   assign tk = op_valid & ~busy;
   assign per = op_file_addr >= 8'h10 && op_file_addr <= 8'h17;

   a_ram_bank_load:
   assert property (tk && op_kind == data_memory_pkg::op_load_ram_bank_literal
      |=> op_done && bank_selector[7:4] == $past(op_data[3:0])) else $error("ram bank load");
   a_periph_bank_load:
   assert property (tk && op_kind == data_memory_pkg::op_load_periph_bank_literal
      |=> op_done && bank_selector[3:0] == $past(op_data[3:0])) else $error("periph bank load");
   a_periph_bank_used:
   assert property ((periph_read || periph_write) |-> ext_bank == bank_selector[3:0]
      && ext_offset >= 8'h10 && ext_offset <= 8'h17) else $error("periph strobe bank");
   a_core_unbanked:
   assert property ((core_read || core_write) |-> ext_bank == 4'h0
      && !(ext_offset >= 8'h10 && ext_offset <= 8'h17)) else $error("core strobe banked");
   a_read_timing:
   assert property (tk && op_kind == data_memory_pkg::op_read
      |=> busy ##1 (op_done && !busy)) else $error("read timing");
   a_move_timing:
   assert property (tk && op_kind inside {data_memory_pkg::op_move_periph_to_file,
      data_memory_pkg::op_move_file_to_periph} |=> busy[*2] ##1 op_done) else $error("move timing");
   a_move_operand:
   assert property (tk && op_kind == data_memory_pkg::op_move_periph_to_file
      && op_periph_addr inside {[5'h10:5'h17]} && bank_selector[3:0] < 4'h8
      |=> periph_read && ext_offset == {3'b000, $past(op_periph_addr)}) else $error("move operand");
   a_absent_ram_zero:
   assert property (tk && op_kind == data_memory_pkg::op_read && op_file_addr >= 8'h20
      && bank_selector[7:4] >= RAM_BANKS |=> ##1 read_data == 8'h00) else $error("absent ram");
   a_absent_periph_zero:
   assert property (tk && op_kind == data_memory_pkg::op_read && per && (bank_selector[3:0] > 8
      || (!HAS_PERIPH_BANK8 && bank_selector[3:0] == 8))
      |=> !periph_read ##1 read_data == 8'h00) else $error("absent periph");
endmodule // data_memory_sva

bind banked_data_memory_decoder data_memory_sva #(.RAM_BANKS(RAM_BANKS),
   .HAS_PERIPH_BANK8(HAS_PERIPH_BANK8)) data_memory_sva_inst (.clock(clock),
   .reset_n(reset_n), .op_valid(op_valid), .op_kind(op_kind), .op_file_addr(op_file_addr),
   .op_periph_addr(op_periph_addr), .op_data(op_data), .busy(busy), .op_done(op_done),
   .read_data(read_data), .core_read(core_read), .core_write(core_write),
   .periph_read(periph_read), .periph_write(periph_write), .ext_bank(ext_bank),
   .ext_offset(ext_offset), .bank_selector(bank_selector));

// ### verification/tb_top.sv
// self-checking bench for the banked data memory decoder
`timescale 1ns/1ps
module tb_top;
   logic                      clock = 1'b0;
   logic                      reset_n = 1'b0;
   logic                      op_valid = 1'b0;
   data_memory_pkg::op_kind_t op_kind = data_memory_pkg::op_read;
   logic [7:0]                op_file_addr = 8'h00;
   logic [4:0]                op_periph_addr = 5'h00;
   logic [7:0]                op_data = 8'h00;
   logic                      busy, op_done, core_read, core_write, periph_read, periph_write;
   logic [3:0]                ext_bank;
   logic [7:0]                ext_offset, ext_write_data, core_read_data, periph_read_data;
   logic [7:0]                read_data, pointer_zero, pointer_one, bank_selector;
   int                        mismatches = 0;
   int                        cmp_count = 0;
   int                        cycles = 0;

   always #10 clock = ~clock;

   banked_data_memory_decoder banked_data_memory_decoder_inst (.clock(clock),
      .reset_n(reset_n), .op_valid(op_valid), .op_kind(op_kind), .op_file_addr(op_file_addr),
      .op_periph_addr(op_periph_addr), .op_data(op_data), .busy(busy), .op_done(op_done),
      .read_data(read_data), .core_read(core_read), .core_write(core_write),
      .periph_read(periph_read), .periph_write(periph_write), .ext_bank(ext_bank),
      .ext_offset(ext_offset), .ext_write_data(ext_write_data),
      .core_read_data(core_read_data), .periph_read_data(periph_read_data),
      .pointer_zero(pointer_zero), .pointer_one(pointer_one), .bank_selector(bank_selector));

   ext_register_model ext_register_model_inst (.clock(clock), .core_read(core_read),
      .core_write(core_write), .periph_read(periph_read), .periph_write(periph_write),
      .ext_bank(ext_bank), .ext_offset(ext_offset), .ext_write_data(ext_write_data),
      .core_read_data(core_read_data), .periph_read_data(periph_read_data));

   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   // run needs under a thousand cycles
   always @(posedge clock) begin
      cycles++;
      if (cycles == 4000) begin
         mismatches++;
         end_sim();
      end
   end

   task automatic chk8(input string nm, input logic [7:0] exp, input logic [7:0] got);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   function automatic logic [7:0] pv(input int b, input int o);
      return 8'(8'h80 + b * 8 + o);
   endfunction

   task automatic op(input data_memory_pkg::op_kind_t k, input logic [7:0] f,
                     input logic [4:0] p, input logic [7:0] d);
      int n;
      @(negedge clock);
      op_valid = 1'b1;
      op_kind = k;
      op_file_addr = f;
      op_periph_addr = p;
      op_data = d;
      @(negedge clock);
      op_valid = 1'b0;
      n = 0;
      while (op_done !== 1'b1 && n < 8) begin
         @(negedge clock);
         n++;
      end
      chk8("op_done", 8'h01, {7'h00, op_done});
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
      op(data_memory_pkg::op_read, a, 5'h00, 8'h00);
      chk8(nm, e, read_data);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      op(data_memory_pkg::op_write, a, 5'h00, d);
   endtask

   task automatic lr(input int b);
      op(data_memory_pkg::op_load_ram_bank_literal, 8'h00, 5'h00, 8'(b));
   endtask

   task automatic lb(input int b);
      op(data_memory_pkg::op_load_periph_bank_literal, 8'h00, 5'h00, 8'(b));
   endtask

   task automatic t_ram_banks;
      for (int b = 0; b < 5; b++) begin
         lr(b);
         chk8("bank_selector", 8'(b * 16), bank_selector);
         wr(8'h40, 8'(8'hf0 + b));
      end
      wr(8'h1a, 8'h5c);
      for (int b = 0; b < 5; b++) begin
         lr(b);
         rd(8'h40, (b < 4) ? 8'(8'hf0 + b) : 8'h00, "ram_page");
         rd(8'h1a, 8'h5c, "shared_ram");
      end
      $display("test ram_banks done");
   endtask

   task automatic t_periph_banks;
      for (int b = 0; b < 10; b++) begin
         lb(b);
         rd(8'(8'h10 + b % 8), (b < 9) ? pv(b, b % 8) : 8'h00, "periph_reg");
         rd(8'h0a, 8'hca, "core_reg");
      end
      wr(8'h0b, 8'h3e);
      rd(8'h0b, 8'h3e, "core_write");
      lb(3);
      wr(8'h13, 8'h3c);
      rd(8'h13, 8'h3c, "periph_write");
      $display("test periph_banks done");
   endtask

   task automatic t_moves;
      lb(2);
      lr(1);
      wr(8'hff, 8'ha5);
      op(data_memory_pkg::op_move_file_to_periph, 8'hff, 5'h1b, 8'h00);
      op(data_memory_pkg::op_move_periph_to_file, 8'h21, 5'h1b, 8'h00);
      rd(8'h21, 8'ha5, "move_spare");
      op(data_memory_pkg::op_move_periph_to_file, 8'h50, 5'h14, 8'h00);
      rd(8'h50, pv(2, 4), "move_periph");
      op(data_memory_pkg::op_move_file_to_periph, 8'h50, 5'h17, 8'h00);
      rd(8'h17, pv(2, 4), "move_back");
      $display("test moves done");
   endtask

   task automatic t_indirect;
      chk8("pointer_zero", 8'h00, pointer_zero);
      lr(2);
      wr(8'h01, 8'h30);
      wr(8'h00, 8'h77);
      rd(8'h30, 8'h77, "indirect_ram");
      lb(1);
      wr(8'h09, 8'h12);
      rd(8'h08, pv(1, 2), "indirect_periph");
      chk8("pointer_one", 8'h12, pointer_one);
      $display("test indirect done");
   endtask

   task automatic t_reset_keeps_ram;
      @(negedge clock);
      reset_n = 1'b0;
      repeat (2) @(negedge clock);
      chk8("bank_selector", 8'h00, bank_selector);
      reset_n = 1'b1;
      repeat (3) @(negedge clock);
      lr(2);
      rd(8'h30, 8'h77, "ram_after_reset");
      rd(8'h40, 8'hf2, "page_after_reset");
      $display("test reset_keeps_ram done");
   endtask

   initial begin
      repeat (10) @(negedge clock);
      reset_n = 1'b1;
      repeat (3) @(negedge clock);
      t_ram_banks();
      t_periph_banks();
      t_moves();
      t_indirect();
      t_reset_keeps_ram();
      end_sim();
   end
endmodule // tb_top
